// ===== rtl/irq_timer_ctrl_map.vh
// opcode, register-map and field constants for the interrupt/timer
// control instruction group; definitions only
`ifndef IRQ_TIMER_CTRL_MAP_VH
`define IRQ_TIMER_CTRL_MAP_VH

// 10-bit instruction codes
`define OP_IRQ_OFF        10'h004
`define OP_IRQ_ON         10'h005
`define OP_SKIP_REQ0      10'h038
`define OP_SKIP_REQ1      10'h039
`define OP_SKIP_PIN0      10'h03A
`define OP_SKIP_PIN1      10'h03B
`define OP_RD_VEC1        10'h054
`define OP_WR_VEC1        10'h03F
`define OP_RD_VEC2        10'h055
`define OP_WR_VEC2        10'h03E
`define OP_RD_EDGE1       10'h253
`define OP_WR_EDGE1       10'h217
`define OP_RD_EDGE2       10'h254
`define OP_WR_EDGE2       10'h218
`define OP_RD_SBIT        10'h255
`define OP_WR_SBIT        10'h21A
`define OP_WR_TSINGLE     10'h2AA
`define OP_RD_TCTRL1      10'h24B
`define OP_WR_TCTRL1      10'h20E
`define OP_RD_TCTRL2      10'h24C
`define OP_WR_TCTRL2      10'h20F
`define OP_RD_TCTRL3      10'h24D
`define OP_WR_TCTRL3      10'h210
`define OP_RD_TCTRL4      10'h24E
`define OP_WR_TCTRL4      10'h211

// control bit positions
`define BIT_EXT0_SKIP_DIS 0
`define BIT_EXT1_SKIP_DIS 1
`define BIT_PIN_POLARITY  2

// reset values
`define NIBBLE_RST        4'h0
`define BIT_RST           1'b0

// register word offsets on the bus (byte address = 4 * index)
`define ADR_STATUS        4'h0
`define ADR_CLEAR         4'h1
`define ADR_ENABLE        4'h2
`define ADR_CTRL          4'h3
`define ADR_IRQ_REGS      4'h4
`define ADR_TMR_REGS      4'h5

// status / control fields
`define EV_EXT0_REQ       0
`define EV_EXT1_REQ       1
`define EV_SKIP           2
`define EV_ILLEGAL        3
`define EV_WIDTH          4
`define CTRL_INTE         0
`define CTRL_REQ0         1
`define CTRL_REQ1         2

`endif

// ===== rtl/irq_timer_ctrl_instr.v
// execution logic for the interrupt and timer control instruction group
// of a 4-bit core, with an avalon-mm register window and one irq line.
// assumes one-cycle instruction issue from the core sequencer, inputs
// synchronous to sys_clk, and the core applying acc_wr / skip_next.
// the bus window only observes the instruction registers: software owns
// the event mask and the clear register and shares the global enable, where
// an instruction wins, so a program and a debugger never race on a control nibble.
// limitation: clk_en low stalls the bus slave too, so a request made
// while frozen waits until the clock runs again.
// also assumes acc_in stands steady while instr_valid is high.
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "irq_timer_ctrl_map.vh"

module irq_timer_ctrl_instr #(
   parameter AW = 4,
   parameter DW = 32
) (
   input  wire          sys_clk,
   input  wire          rstn,
   input  wire          clk_en,
   input  wire          instr_valid,
   input  wire [9:0]    instr_code,
   input  wire [3:0]    acc_in,
   input  wire          ext_irq_pin_zero,
   input  wire          ext_irq_pin_one,
   input  wire          ext_req_set_zero,
   input  wire          ext_req_set_one,
   input  wire [AW-1:0] avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [DW-1:0] avs_writedata,
   output reg  [DW-1:0] avs_readdata,
   output reg           avs_waitrequest,
   output reg  [3:0]    acc_out,
   output reg           acc_wr,
   output reg           skip_next,
   output reg           irq_enable,
   output reg           ext_request_flag_zero,
   output reg           ext_request_flag_one,
   output reg           irq
);

   // instruction side control registers
   reg [3:0] vec_ctrl_reg_first;
   reg [3:0] vec_ctrl_reg_second;
   reg [3:0] edge_ctrl_reg_first;
   reg [3:0] edge_ctrl_reg_second;
   reg       single_bit_irq_ctrl_reg;
   reg       timer_single_ctrl_reg;
   reg [3:0] timer_ctrl_reg_one;
   reg [3:0] timer_ctrl_reg_two;
   reg [3:0] timer_ctrl_reg_three;
   reg [3:0] timer_ctrl_reg_four;

   // interrupt bookkeeping
   reg [`EV_WIDTH-1:0] irq_status;
   reg [`EV_WIDTH-1:0] irq_mask;
   reg [`EV_WIDTH-1:0] events;
   reg [`CTRL_REQ1:0]  ctrl_word;

   // decoded results of the current instruction
   reg       next_acc_wr;
   reg [3:0] next_acc;
   reg       next_skip;
   reg       next_inte_set;
   reg       next_inte_clr;
   reg       next_clr_req0;
   reg       next_clr_req1;
   reg       next_illegal;
   reg [3:0] next_wsel;

   // qualified strobes of the instruction port and the bus
   wire      exec;
   wire      bus_req;
   wire      bus_ack;
   wire      bus_wr;
   wire [`EV_WIDTH-1:0] clr_bits;

   wire ext_zero_skip_disable = vec_ctrl_reg_first[`BIT_EXT0_SKIP_DIS];
   wire ext_one_skip_disable  = vec_ctrl_reg_first[`BIT_EXT1_SKIP_DIS];
   wire pin_zero_polarity_sel = edge_ctrl_reg_first[`BIT_PIN_POLARITY];
   wire pin_one_polarity_sel  = edge_ctrl_reg_second[`BIT_PIN_POLARITY];

   // write-target codes for next_wsel; W_NONE leaves every register
   // alone, so an undefined code can never corrupt a control nibble
   localparam [3:0] W_NONE  = 4'h0;
   localparam [3:0] W_VEC1  = 4'h1;
   localparam [3:0] W_VEC2  = 4'h2;
   localparam [3:0] W_EDGE1 = 4'h3;
   localparam [3:0] W_EDGE2 = 4'h4;
   localparam [3:0] W_SBIT  = 4'h5;
   localparam [3:0] W_TSGL  = 4'h6;
   localparam [3:0] W_T1    = 4'h7;
   localparam [3:0] W_T2    = 4'h8;
   localparam [3:0] W_T3    = 4'h9;
   localparam [3:0] W_T4    = 4'hA;

   // level test shared by both pin skips
   // polarity high skips on a high pin, low on a low pin
   function pin_skip;
      input level;
      input polarity;
      begin
         pin_skip = polarity ? level : ~level;
      end
   endfunction

   // widen a 24-bit group of fields onto the bus word
   function [DW-1:0] zext;
      input [23:0] v;
      begin
         zext = {{(DW-24){1'b0}}, v};
      end
   endfunction

   // an instruction or a bus beat counts only on an enabled edge
   assign exec    = clk_en & instr_valid;
   assign bus_req = avs_read | avs_write;
   assign bus_ack = clk_en & bus_req & ~avs_waitrequest;
   assign bus_wr  = bus_ack & avs_write;

   // instruction decode: each instruction is one word, one cycle, and
   // none of them touches the carry flag (there is no carry port here)
   always @* begin
      next_acc_wr   = 1'b0;
      next_acc      = acc_in;
      next_skip     = 1'b0;
      next_inte_set = 1'b0;
      next_inte_clr = 1'b0;
      next_clr_req0 = 1'b0;
      next_clr_req1 = 1'b0;
      next_illegal  = 1'b0;
      next_wsel     = W_NONE;
      case (instr_code)
         `OP_IRQ_OFF:   next_inte_clr = 1'b1;
         `OP_IRQ_ON:    next_inte_set = 1'b1;
         `OP_SKIP_REQ0: begin
            // disabled test is a plain nop, flag left alone
            if (!ext_zero_skip_disable && ext_request_flag_zero) begin
               next_skip     = 1'b1;
               next_clr_req0 = 1'b1;
            end
         end
         `OP_SKIP_REQ1: begin
            if (!ext_one_skip_disable && ext_request_flag_one) begin
               next_skip     = 1'b1;
               next_clr_req1 = 1'b1;
            end
         end
         `OP_SKIP_PIN0:
            next_skip = pin_skip(ext_irq_pin_zero, pin_zero_polarity_sel);
         `OP_SKIP_PIN1:
            next_skip = pin_skip(ext_irq_pin_one, pin_one_polarity_sel);
         `OP_RD_VEC1: begin
            next_acc_wr = 1'b1;
            next_acc    = vec_ctrl_reg_first;
         end
         `OP_RD_VEC2: begin
            next_acc_wr = 1'b1;
            next_acc    = vec_ctrl_reg_second;
         end
         `OP_WR_VEC1:   next_wsel = W_VEC1;
         `OP_WR_VEC2:   next_wsel = W_VEC2;
         `OP_RD_EDGE1: begin
            next_acc_wr = 1'b1;
            next_acc    = edge_ctrl_reg_first;
         end
         `OP_RD_EDGE2: begin
            next_acc_wr = 1'b1;
            next_acc    = edge_ctrl_reg_second;
         end
         `OP_WR_EDGE1:  next_wsel = W_EDGE1;
         `OP_WR_EDGE2:  next_wsel = W_EDGE2;
         // only bit zero is stored; the upper accumulator bits read low
         `OP_RD_SBIT: begin
            next_acc_wr = 1'b1;
            next_acc    = {3'h0, single_bit_irq_ctrl_reg};
         end
         `OP_WR_SBIT:   next_wsel = W_SBIT;
         // no read opcode exists for the timer single-bit register
         `OP_WR_TSINGLE: next_wsel = W_TSGL;
         `OP_RD_TCTRL1: begin
            next_acc_wr = 1'b1;
            next_acc    = timer_ctrl_reg_one;
         end
         `OP_RD_TCTRL2: begin
            next_acc_wr = 1'b1;
            next_acc    = timer_ctrl_reg_two;
         end
         `OP_RD_TCTRL3: begin
            next_acc_wr = 1'b1;
            next_acc    = timer_ctrl_reg_three;
         end
         `OP_RD_TCTRL4: begin
            next_acc_wr = 1'b1;
            next_acc    = timer_ctrl_reg_four;
         end
         `OP_WR_TCTRL1: next_wsel = W_T1;
         `OP_WR_TCTRL2: next_wsel = W_T2;
         `OP_WR_TCTRL3: next_wsel = W_T3;
         `OP_WR_TCTRL4: next_wsel = W_T4;
         default:       next_illegal = 1'b1;
      endcase
   end

   // accumulator and skip handshake back to the core, one cycle each
   // acc_out holds between loads, so a late core sample still sees it
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc_out   <= `NIBBLE_RST;
         acc_wr    <= 1'b0;
         skip_next <= 1'b0;
      end else if (clk_en) begin
         acc_wr    <= instr_valid & next_acc_wr;
         skip_next <= instr_valid & next_skip;
         if (instr_valid & next_acc_wr)
            acc_out <= next_acc;
      end
   end

   // control registers: whole-nibble replacement from the accumulator, bit zero only for the two single-bit registers
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         vec_ctrl_reg_first      <= `NIBBLE_RST;
         vec_ctrl_reg_second     <= `NIBBLE_RST;
         edge_ctrl_reg_first     <= `NIBBLE_RST;
         edge_ctrl_reg_second    <= `NIBBLE_RST;
         single_bit_irq_ctrl_reg <= `BIT_RST;
         timer_single_ctrl_reg   <= `BIT_RST;
         timer_ctrl_reg_one      <= `NIBBLE_RST;
         timer_ctrl_reg_two      <= `NIBBLE_RST;
         timer_ctrl_reg_three    <= `NIBBLE_RST;
         timer_ctrl_reg_four     <= `NIBBLE_RST;
      end else if (exec) begin
         // lands on the execute edge, so a read one cycle later sees it
         case (next_wsel)
            W_VEC1:  vec_ctrl_reg_first      <= acc_in;
            W_VEC2:  vec_ctrl_reg_second     <= acc_in;
            W_EDGE1: edge_ctrl_reg_first     <= acc_in;
            W_EDGE2: edge_ctrl_reg_second    <= acc_in;
            W_SBIT:  single_bit_irq_ctrl_reg <= acc_in[0];
            W_TSGL:  timer_single_ctrl_reg   <= acc_in[0];
            W_T1:    timer_ctrl_reg_one      <= acc_in;
            W_T2:    timer_ctrl_reg_two      <= acc_in;
            W_T3:    timer_ctrl_reg_three    <= acc_in;
            W_T4:    timer_ctrl_reg_four     <= acc_in;
            default: ;
         endcase
      end
   end

   // global enable: an instruction in the same cycle beats a bus write,
   // since the program is the owner of this flag
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         irq_enable <= 1'b0;
      else if (exec && next_inte_clr)
         irq_enable <= 1'b0;
      else if (exec && next_inte_set)
         irq_enable <= 1'b1;
      else if (bus_wr && avs_address == `ADR_CTRL)
         irq_enable <= avs_writedata[`CTRL_INTE];
   end

   // request flags: a new request in the clearing cycle survives
   // the pins' edge detection sits outside; set inputs are pulses
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_request_flag_zero <= 1'b0;
         ext_request_flag_one  <= 1'b0;
      end else if (clk_en) begin
         if (ext_req_set_zero)
            ext_request_flag_zero <= 1'b1;
         else if (instr_valid && next_clr_req0)
            ext_request_flag_zero <= 1'b0;
         if (ext_req_set_one)
            ext_request_flag_one <= 1'b1;
         else if (instr_valid && next_clr_req1)
            ext_request_flag_one <= 1'b0;
      end
   end

   // events placed by field, so the layout is set only in the map header
   always @* begin
      events               = {`EV_WIDTH{1'b0}};
      events[`EV_EXT0_REQ] = ext_req_set_zero;
      events[`EV_EXT1_REQ] = ext_req_set_one;
      events[`EV_SKIP]     = exec & next_skip;
      events[`EV_ILLEGAL]  = exec & next_illegal;
   end

   // sticky status; an event beats a clear in the same cycle
   assign clr_bits = (bus_wr && avs_address == `ADR_CLEAR) ?
                     avs_writedata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_status <= {`EV_WIDTH{1'b0}};
         irq_mask   <= {`EV_WIDTH{1'b0}};
         irq        <= 1'b0;
      end else if (clk_en) begin
         irq_status <= (irq_status & ~clr_bits) | events;
         // mask writes land on the acknowledge edge, like every bus write
         if (bus_wr && avs_address == `ADR_ENABLE)
            irq_mask <= avs_writedata[`EV_WIDTH-1:0];
         // one cycle behind the status bits, to keep irq a flop output
         irq <= |(irq_status & irq_mask);
      end
   end

   // control word for the bus, placed by field like the status bits
   always @* begin
      ctrl_word             = 3'h0;
      ctrl_word[`CTRL_INTE] = irq_enable;
      ctrl_word[`CTRL_REQ0] = ext_request_flag_zero;
      ctrl_word[`CTRL_REQ1] = ext_request_flag_one;
   end

   // avalon slave: every access waits exactly one cycle, then completes;
   // the fixed wait lets the read mux be a register with no bypass path
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         avs_waitrequest <= 1'b1;
      else if (clk_en) begin
         if (!avs_waitrequest)
            avs_waitrequest <= 1'b1;
         else if (bus_req)
            avs_waitrequest <= 1'b0;
      end
   end

   // read data captured in the wait cycle, held until the next read
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         avs_readdata <= {DW{1'b0}};
      else if (clk_en && avs_waitrequest && avs_read) begin
         case (avs_address)
            `ADR_STATUS:   avs_readdata <= zext({20'h0, irq_status});
            `ADR_ENABLE:   avs_readdata <= zext({20'h0, irq_mask});
            `ADR_CTRL:     avs_readdata <= zext({21'h0, ctrl_word});
            `ADR_IRQ_REGS: avs_readdata <= zext({7'h0,
                              single_bit_irq_ctrl_reg,
                              edge_ctrl_reg_second, edge_ctrl_reg_first,
                              vec_ctrl_reg_second, vec_ctrl_reg_first});
            `ADR_TMR_REGS: avs_readdata <= zext({7'h0,
                              timer_single_ctrl_reg,
                              timer_ctrl_reg_four, timer_ctrl_reg_three,
                              timer_ctrl_reg_two, timer_ctrl_reg_one});
            default:       avs_readdata <= {DW{1'b0}};
         endcase
      end
   end

endmodule

// ===== bench/irq_timer_ctrl_checker.sv
// assertion checker for the interrupt/timer instruction group
// assumes binding to the block top; it sees only its ports
`timescale 1ns/10ps
`include "irq_timer_ctrl_map.vh"
module irq_timer_ctrl_checker (
   input wire       sys_clk,
   input wire       rstn,
   input wire       clk_en,
   input wire       instr_valid,
   input wire [9:0] instr_code,
   input wire       ext_req_set_zero,
   input wire       ext_req_set_one,
   input wire [3:0] acc_out,
   input wire       acc_wr,
   input wire       skip_next,
   input wire       irq_enable,
   input wire       ext_request_flag_zero,
   input wire       ext_request_flag_one
);
   // an instruction counts only on an enabled edge
   wire ex = clk_en && instr_valid;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_irq_off_clears: assert property (ex && instr_code == `OP_IRQ_OFF |=> !irq_enable)
      else $error("irq enable set after irq-off");
   a_irq_on_sets: assert property (ex && instr_code == `OP_IRQ_ON |=> irq_enable)
      else $error("irq enable clear after irq-on");
   a_ext0_no_skip: assert property (ex && instr_code == `OP_SKIP_REQ0 &&
      !ext_request_flag_zero && !ext_req_set_zero |=> !skip_next)
      else $error("ext0 test skipped with flag clear");
   a_ext0_skip_clears: assert property (ex && instr_code == `OP_SKIP_REQ0 &&
      !ext_req_set_zero ##1 skip_next |-> !ext_request_flag_zero)
      else $error("ext0 flag kept after skip");
   a_ext1_no_skip: assert property (ex && instr_code == `OP_SKIP_REQ1 &&
      !ext_request_flag_one && !ext_req_set_one |=> !skip_next)
      else $error("ext1 test skipped with flag clear");
   a_sbit_upper_zero: assert property (ex && instr_code == `OP_RD_SBIT |=>
      acc_wr && acc_out[3:1] == 3'b000)
      else $error("single bit read upper bits not zero");
   a_vec_read_loads: assert property (ex && (instr_code == `OP_RD_VEC1 ||
      instr_code == `OP_RD_VEC2) |=> acc_wr && !skip_next)
      else $error("vector register read gave no load");
   a_idle_one_cycle: assert property (clk_en && !instr_valid |=> !acc_wr && !skip_next)
      else $error("pulse without an instruction");
   a_flag_zero_holds: assert property (!ext_req_set_zero &&
      !(ex && instr_code == `OP_SKIP_REQ0) |=> $stable(ext_request_flag_zero))
      else $error("ext0 flag changed without cause");

   c_skip_taken: cover property (skip_next);
   c_acc_load: cover property (acc_wr);
   c_irq_on: cover property ($rose(irq_enable));
endmodule

bind irq_timer_ctrl_instr irq_timer_ctrl_checker chk_u (
   .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .instr_valid(instr_valid),
   .instr_code(instr_code), .ext_req_set_zero(ext_req_set_zero),
   .ext_req_set_one(ext_req_set_one), .acc_out(acc_out), .acc_wr(acc_wr),
   .skip_next(skip_next), .irq_enable(irq_enable),
   .ext_request_flag_zero(ext_request_flag_zero),
   .ext_request_flag_one(ext_request_flag_one));

// ===== bench/core_seq_model.sv
// core-side model: the accumulator the block reads and writes back
// assumes acc_wr and skip_next pulse one cycle after the execute edge
`timescale 1ns/10ps
module core_seq_model (
   input  wire       sys_clk,
   input  wire       rstn,
   input  wire       acc_wr,
   input  wire [3:0] acc_out,
   input  wire       skip_next,
   input  wire       load_en,
   input  wire [3:0] load_val,
   output reg  [3:0] acc,
   output reg        skipped
);
   // bench preload wins so a test can set the operand
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc <= 4'h0;
         skipped <= 1'b0;
      end else begin
         if (load_en)
            acc <= load_val;
         else if (acc_wr)
            acc <= acc_out;
         skipped <= skip_next;
      end
   end
endmodule

// ===== bench/tb_irq_timer_ctrl_instr.sv
// bench top: instruction and avalon tasks with expected values
// assumes the core model and the block opcode header
`timescale 1ns/10ps
`include "irq_timer_ctrl_map.vh"
module tb_irq_timer_ctrl_instr;
   localparam [79:0] WR_OPS = {`OP_WR_TCTRL4, `OP_WR_TCTRL3, `OP_WR_TCTRL2, `OP_WR_TCTRL1,
      `OP_WR_EDGE2, `OP_WR_EDGE1, `OP_WR_VEC2, `OP_WR_VEC1};
   localparam [79:0] RD_OPS = {`OP_RD_TCTRL4, `OP_RD_TCTRL3, `OP_RD_TCTRL2, `OP_RD_TCTRL1,
      `OP_RD_EDGE2, `OP_RD_EDGE1, `OP_RD_VEC2, `OP_RD_VEC1};
   reg         sys_clk, rstn, clk_en, instr_valid, pin0, pin1, set0, set1, ld_en;
   reg         avs_read, avs_write;
   reg  [9:0]  code;
   reg  [3:0]  acc_ld, avs_address;
   reg  [31:0] avs_writedata, d;
   wire [31:0] rdata;
   wire [3:0]  acc_in, acc_out;
   wire        wreq, acc_wr, skip, inte, f0, f1, irq;
   integer     errors, cmp_count, cyc, i;

   irq_timer_ctrl_instr dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .instr_valid(instr_valid),
      .instr_code(code), .acc_in(acc_in), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
      .ext_req_set_zero(set0), .ext_req_set_one(set1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .acc_out(acc_out), .acc_wr(acc_wr),
      .skip_next(skip), .irq_enable(inte), .ext_request_flag_zero(f0),
      .ext_request_flag_one(f1), .irq(irq));
   core_seq_model core_u (
      .sys_clk(sys_clk), .rstn(rstn), .acc_wr(acc_wr), .acc_out(acc_out), .skip_next(skip),
      .load_en(ld_en), .load_val(acc_ld), .acc(acc_in), .skipped());

   task cmp(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %0s expected %0h got %0h", name, exp, got);
         end
      end
   endtask

   // preload the accumulator one edge ahead, then issue for one edge
   task exec(input [9:0] op, input [3:0] a);
      begin
         @(posedge sys_clk);
         ld_en <= 1'b1;
         acc_ld <= a;
         @(posedge sys_clk);
         ld_en <= 1'b0;
         instr_valid <= 1'b1;
         code <= op;
         @(posedge sys_clk);
         instr_valid <= 1'b0;
         #1;
      end
   endtask

   // held until waitrequest is seen low; only the timeout ends a hang
   task bus(input wr, input [3:0] adr, input [31:0] wd);
      begin
         @(posedge sys_clk);
         avs_address <= adr;
         avs_writedata <= wd;
         avs_read <= !wr;
         avs_write <= wr;
         @(posedge sys_clk);
         while (wreq !== 1'b0)
            @(posedge sys_clk);
         d = rdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         #1;
      end
   endtask

   task pulse(input integer k);
      begin
         @(posedge sys_clk);
         set0 <= (k == 0);
         set1 <= (k == 1);
         @(posedge sys_clk);
         set0 <= 1'b0;
         set1 <= 1'b0;
         #1;
      end
   endtask

   task report_and_stop;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         errors = errors + 1;
         report_and_stop;
      end
   end

   initial begin
      {instr_valid, pin0, pin1, set0, set1, ld_en, avs_read, avs_write} = 8'h00;
      {rstn, clk_en} = 2'b01;
      code = 10'h000;
      acc_ld = 4'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      {errors, cmp_count, cyc} = 96'h0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      cmp("waitreq", 1, wreq);
      cmp("inte", 0, inte);
      bus(1'b0, `ADR_IRQ_REGS, 32'h0);
      cmp("irq_regs", 0, d);
      // nibble moves out, then back with a zeroed accumulator
      for (i = 0; i < 8; i = i + 1)
         exec(WR_OPS[i*10 +: 10], i[3:0] ^ 4'h9);
      for (i = 0; i < 8; i = i + 1) begin
         exec(RD_OPS[i*10 +: 10], 4'h0);
         cmp("acc_wr", 1, acc_wr);
         cmp("acc_out", i[3:0] ^ 4'h9, acc_out);
      end
      exec(`OP_WR_TCTRL1, 4'h6);
      exec(`OP_RD_TCTRL1, 4'h0);
      cmp("acc_out", 4'h6, acc_out);
      exec(`OP_WR_SBIT, 4'hF);
      exec(`OP_RD_SBIT, 4'hA);
      cmp("acc_out", 4'h1, acc_out);
      exec(`OP_WR_SBIT, 4'hE);
      exec(`OP_RD_SBIT, 4'hF);
      cmp("acc_out", 4'h0, acc_out);
      exec(`OP_WR_TSINGLE, 4'h3);
      bus(1'b0, `ADR_TMR_REGS, 32'h0);
      cmp("tmr_regs", 32'h0001EFC6, d);
      bus(1'b0, `ADR_IRQ_REGS, 32'h0);
      cmp("irq_regs", 32'h0000AB89, d);
      // request flag tests, enabled then disabled
      for (i = 0; i < 2; i = i + 1) begin
         exec(`OP_WR_VEC1, 4'h0);
         pulse(i);
         exec(`OP_SKIP_REQ0 | i[9:0], 4'h0);
         cmp("skip", 1, skip);
         cmp("flag", 0, (i == 0) ? f0 : f1);
         exec(`OP_SKIP_REQ0 | i[9:0], 4'h0);
         cmp("skip", 0, skip);
         exec(`OP_WR_VEC1, 4'h3);
         pulse(i);
         exec(`OP_SKIP_REQ0 | i[9:0], 4'h0);
         cmp("skip", 0, skip);
         cmp("flag", 1, (i == 0) ? f0 : f1);
      end
      // pin level tests over pin, polarity and level
      for (i = 0; i < 8; i = i + 1) begin
         exec(i[2] ? `OP_WR_EDGE2 : `OP_WR_EDGE1, {1'b0, i[1], 2'b00});
         @(posedge sys_clk);
         pin0 <= i[0];
         pin1 <= i[0];
         exec(`OP_SKIP_PIN0 | {9'h0, i[2]}, 4'h0);
         cmp("skip_pin", i[1] == i[0], skip);
      end
      // sticky status, illegal code, raise, clear and mask of irq
      bus(1'b0, `ADR_STATUS, 32'h0);
      cmp("status", 32'h7, d);
      cmp("irq", 0, irq);
      exec(10'h3FF, 4'h0);
      bus(1'b1, `ADR_ENABLE, 32'h8);
      repeat (2) @(posedge sys_clk);
      #1;
      cmp("irq", 1, irq);
      bus(1'b1, `ADR_CLEAR, 32'h8);
      repeat (2) @(posedge sys_clk);
      #1;
      cmp("irq", 0, irq);
      bus(1'b0, `ADR_STATUS, 32'h0);
      cmp("status", 32'h7, d);
      bus(1'b1, `ADR_CTRL, 32'h1);
      cmp("inte", 1, inte);
      exec(`OP_IRQ_OFF, 4'h0);
      cmp("inte", 0, inte);
      exec(`OP_IRQ_ON, 4'h0);
      cmp("inte", 1, inte);
      // clock enable low: instructions must leave every flop alone
      @(posedge sys_clk);
      clk_en <= 1'b0;
      exec(`OP_IRQ_OFF, 4'h0);
      cmp("frozen", 1, inte);
      exec(`OP_RD_VEC1, 4'h0);
      cmp("frz_load", 0, acc_wr);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      bus(1'b0, `ADR_CTRL, 32'h0);
      cmp("ctrl", 32'h7, d);
      bus(1'b0, 4'hF, 32'h0);
      cmp("unmapped", 0, d);
      report_and_stop;
   end
endmodule
